// file: bench/tec_driver_output_control_bench.sv
/* Self-checking bench of the TEC output control block.
   Assumes the far side model and the bound checker. */
`timescale 1ns/1ps
`define check_eq(g, w) begin samples_checked++; if ((g) !== (w)) begin bad_count++; \
   $display("unexpected at %0t: got %h want %h", $time, g, w); end end

module tec_driver_output_control_bench;
   typedef struct {
      logic        wr;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0]  r;
   } row_t;
   logic               clk_i, srst_i, convert, front_panel_on_i, conv_tick, hw_fault_o, irq_o;
   logic signed [15:0] pid_value_i, tec_current_o;
   logic [15:0]        vmon;
   logic [31:0]        res, rd, wdata, rdata;
   logic [7:0]         awaddr, araddr;
   logic [1:0]         resp, bresp, rresp;
   logic               awvalid, awready, wvalid, wready, bvalid, bready;
   logic               arvalid, arready, rvalid, rready;
   tec_pkg::meas_t     meas;
   tec_pkg::exc_t      excitation_sel_o;
   int                 bad_count = 0, samples_checked = 0;
   row_t rows[10] = '{'{1'h0, 8'h00, 32'h0, 32'h0, 2'h0}, '{1'h0, 8'h04, 32'h0, 32'h64, 2'h0},
      '{1'h0, 8'h0c, 32'h0, 32'hffff, 2'h0}, '{1'h0, 8'h20, 32'h0, 32'h64, 2'h0},
      '{1'h0, 8'h1c, 32'h0, 32'h0, 2'h0}, '{1'h1, 8'h04, 32'h3e8, 32'h3e8, 2'h0},
      '{1'h1, 8'h04, 32'h5dc, 32'h3e8, 2'h0}, '{1'h1, 8'h04, 32'h0, 32'h0, 2'h0},
      '{1'h1, 8'h14, 32'h55, 32'h0, 2'h0}, '{1'h1, 8'h24, 32'h1, 32'h0, 2'h2}};
   logic [31:0] ares[9] = '{32'h5dc, 32'h7d0, 32'h5dc, 32'h3e7, 32'h7d0, 32'h3a98,
      32'h4e21, 32'h3a98, 32'h2710};
   logic [1:0] aexc[9] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1};

   // Short trip time so the persistence window fits the run
   tec_driver_output_control #(.OV_CYCLES(20)) dut (
      .clk_i, .srst_i, .conv_tick_i(conv_tick), .meas_i(meas), .pid_value_i,
      .front_panel_on_i, .tec_current_o, .excitation_sel_o, .hw_fault_o, .irq_o,
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   tec_far_side_model far (.clk_i, .srst_i, .convert_i(convert), .vmon_mv_i(vmon),
      .res_ohm_i(res), .conv_tick_o(conv_tick), .meas_o(meas));

   initial begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic [1:0] p;
      p = 2'h3;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (p != 2'h0) begin
         @(posedge clk_i);
         if (p[1] && awready === 1'h1) begin
            p[1] = 1'h0;
            awvalid <= 1'h0;
         end
         if (p[0] && wready === 1'h1) begin
            p[0] = 1'h0;
            wvalid <= 1'h0;
         end
      end
      do @(posedge clk_i); while (bvalid !== 1'h1);
      r = bresp;
      bready <= 1'h0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge clk_i); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge clk_i); while (rvalid !== 1'h1);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask : axi_rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      `check_eq(r, 2'h0)
   endtask : wr

   // One conversion, then the slewed current is compared
   task automatic step(input logic signed [15:0] e);
      @(posedge clk_i);
      convert <= 1'h1;
      @(posedge clk_i);
      convert <= 1'h0;
      repeat (3) @(posedge clk_i);
      `check_eq(tec_current_o, e)
   endtask : step

   task automatic hold(input logic [15:0] v, input int n);
      vmon <= v;
      repeat (n) @(posedge clk_i);
   endtask : hold

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      conclude();
   end

   initial begin
      srst_i = 1'h1;
      front_panel_on_i = 1'h1;
      pid_value_i = -16'sh3e8;
      {convert, awvalid, wvalid, bready, arvalid, rready, vmon, res} = '0;
      {awaddr, araddr, wdata} = '0;
      repeat (10) @(posedge clk_i);
      srst_i <= 1'h0;
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            axi_wr(rows[i].a, rows[i].d, resp);
            `check_eq(resp, rows[i].r)
         end
         axi_rd(rows[i].a, rd, resp);
         `check_eq(rd, rows[i].e)
         `check_eq(resp, rows[i].r)
      end
      for (int m = 0; m < 3; m++) begin
         wr(8'h00, 32'(m));
         step(16'sh0);
         `check_eq(excitation_sel_o, tec_pkg::exc_t'(m))
      end
      res <= 32'h1f4;
      wr(8'h00, 32'h7);
      step(16'sh0);
      step(16'sh0);
      `check_eq(excitation_sel_o, tec_pkg::EXC_1MA)
      for (int i = 0; i < 9; i++) begin
         res <= ares[i];
         step(16'sh0);
         `check_eq(excitation_sel_o, tec_pkg::exc_t'(aexc[i]))
      end
      wr(8'h00, 32'h3);
      res <= 32'h7530;
      step(16'sh0);
      `check_eq(excitation_sel_o, tec_pkg::EXC_1MA)
      wr(8'h20, 32'h1);
      wr(8'h04, 32'h3e8);
      wr(8'h08, 32'h9c4);
      wr(8'h00, 32'h8);
      step(16'sh3e8);
      step(16'sh7d0);
      step(16'sh9c4);
      wr(8'h08, 32'hfffffe0c);
      step(16'sh5dc);
      step(16'sh1f4);
      step(-16'sh1f4);
      repeat (20) @(posedge clk_i);
      `check_eq(tec_current_o, -16'sh1f4)
      wr(8'h08, 32'h9c4);
      step(16'sh1f4);
      front_panel_on_i <= 1'h0;
      repeat (10) @(posedge clk_i);
      `check_eq(tec_current_o, 16'sh0)
      step(16'sh0);
      front_panel_on_i <= 1'h1;
      repeat (10) @(posedge clk_i);
      step(16'sh3e8);
      step(16'sh7d0);
      step(16'sh9c4);
      wr(8'h00, 32'h18);
      step(16'sh5dc);
      wr(8'h00, 32'h8);
      step(16'sh9c4);
      wr(8'h18, 32'h7);
      wr(8'h1c, 32'h3);
      wr(8'h0c, 32'h3e8);
      `check_eq(irq_o, 1'h0)
      hold(16'h3e9, 15);
      hold(16'h3e8, 3);
      hold(16'h3e9, 15);
      hold(16'h0, 3);
      `check_eq(hw_fault_o, 1'h0)
      `check_eq(tec_current_o, 16'sh9c4)
      hold(16'h3e9, 30);
      hold(16'h0, 3);
      `check_eq(tec_current_o, 16'sh0)
      `check_eq(hw_fault_o, 1'h1)
      `check_eq(irq_o, 1'h1)
      step(16'sh0);
      axi_rd(8'h18, rd, resp);
      `check_eq(rd, 32'h3)
      wr(8'h18, 32'h1);
      repeat (3) @(posedge clk_i);
      `check_eq(irq_o, 1'h1)
      wr(8'h18, 32'h2);
      repeat (3) @(posedge clk_i);
      `check_eq(irq_o, 1'h0)
      wr(8'h08, 32'h0);
      step(16'sh0);
      wr(8'h08, 32'h1f4);
      step(16'sh1f4);
      wr(8'h1c, 32'h0);
      hold(16'h3e9, 30);
      hold(16'h0, 3);
      `check_eq(tec_current_o, 16'sh0)
      `check_eq(irq_o, 1'h0)
      axi_rd(8'h18, rd, resp);
      `check_eq(rd, 32'h1)
      conclude();
   end
endmodule : tec_driver_output_control_bench

// file: bench/tec_far_side_model.sv
/* Far side model: conversion pulse, voltage monitor and sensor reading.
   Assumes the bench asks for each conversion and sets the physical values. */
`timescale 1ns/1ps

module tec_far_side_model (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        convert_i,
   input  wire logic [15:0] vmon_mv_i,
   input  wire logic [31:0] res_ohm_i,
   output logic             conv_tick_o,
   output tec_pkg::meas_t   meas_o
);
   // Voltage is watched every cycle; resistance only refreshes per conversion
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         conv_tick_o <= 1'h0;
         meas_o <= '0;
      end else begin
         conv_tick_o <= convert_i;
         meas_o.vmon_mv <= vmon_mv_i;
         if (convert_i) begin
            meas_o.res_ohm <= res_ohm_i;
            meas_o.valid <= 1'h1;
         end
      end
   end
endmodule : tec_far_side_model

// file: bench/tec_output_chk_sva.sv
/* Checker: port-level properties of the TEC output control block.
   Assumes it is bound into the block and sees one clock domain. */
`timescale 1ns/1ps

module tec_output_chk #(
   parameter int CW = 16
) (
   input wire logic                 clk_i,
   input wire logic                 srst_i,
   input wire logic                 conv_tick_i,
   input wire logic                 front_panel_on_i,
   input wire logic signed [CW-1:0] tec_current_o,
   input wire tec_pkg::exc_t        excitation_sel_o,
   input wire logic                 hw_fault_o,
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   property p_exc_legal; excitation_sel_o != 2'h3; endproperty
   a_exc_legal: assert property (p_exc_legal)
      else $error("excitation code out of range");
   // Only a tick may move the current away from zero or between values
   property p_tick_move; $changed(tec_current_o) && tec_current_o != '0 |-> $past(conv_tick_i);
   endproperty
   a_tick_move: assert property (p_tick_move)
      else $error("current moved without a conversion tick");
   property p_off_zero; !front_panel_on_i [*8] |-> tec_current_o == '0; endproperty
   a_off_zero: assert property (p_off_zero)
      else $error("current not zero with outputs off");
   property p_fault_keep; hw_fault_o |=> hw_fault_o; endproperty
   a_fault_keep: assert property (p_fault_keep)
      else $error("fault indication dropped");
   property p_fault_off; $rose(hw_fault_o) |-> ##[0:1] tec_current_o == '0; endproperty
   a_fault_off: assert property (p_fault_off)
      else $error("current not cut at shutdown");
   property p_wlat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_wlat: assert property (p_wlat)
      else $error("write response late or early");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat)
      else $error("read data late");
   property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
   a_rdone: assert property (p_rdone)
      else $error("read channel not released");

   c_fault: cover property ($rose(hw_fault_o));
   c_move: cover property ($changed(tec_current_o));
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : tec_output_chk

bind tec_driver_output_control tec_output_chk #(.CW(CW)) chk (
   .clk_i, .srst_i, .conv_tick_i, .front_panel_on_i, .tec_current_o, .excitation_sel_o,
   .hw_fault_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

// file: verilog/tec_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the TEC
 * driver output control block.
 * Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TEC_OFF_CTRL     8'h00
`define TEC_OFF_SLEW     8'h04
`define TEC_OFF_SETP     8'h08
`define TEC_OFF_VMAX     8'h0c
`define TEC_OFF_STATUS   8'h10
`define TEC_OFF_OUTPUT   8'h14
`define TEC_OFF_IRQ_STAT 8'h18
`define TEC_OFF_IRQ_MASK 8'h1c
`define TEC_OFF_IVL      8'h20

// ----------------------------------------------------------------------
// Field encodings and reset values
// ----------------------------------------------------------------------
`define TEC_MODE_1MA     2'h0
`define TEC_MODE_100UA   2'h1
`define TEC_MODE_10UA    2'h2
`define TEC_MODE_AUTO    2'h3
`define TEC_CTRL_RST     5'h00
`define TEC_SLEW_RST     10'h064
`define TEC_SLEW_MAX     10'h3e8
`define TEC_VMAX_RST     16'hffff
`define TEC_IVL_RST      16'h0064
`define TEC_IRQ_TRIP     0
`define TEC_IRQ_FAULT    1
`define TEC_IRQ_EXC      2
`define TEC_RESP_OKAY    2'h0
`define TEC_RESP_SLVERR  2'h2

// ----------------------------------------------------------------------
// Auto excitation thresholds in ohms
// ----------------------------------------------------------------------
`define TEC_R_LO_DOWN    32'h0000_03e8
`define TEC_R_LO_UP      32'h0000_07d0
`define TEC_R_HI_DOWN    32'h0000_2710
`define TEC_R_HI_UP      32'h0000_4e20

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TEC_CLK_KHZ      125000
`define TEC_OV_TIME_MS   1000

`endif

// file: verilog/tec_driver_output_control.sv
/*
 * TEC driver output control: excitation selection, slew-limited TEC
 * current, global output switch and overvoltage shutdown, with an
 * AXI4-Lite register slave and a level interrupt.
 * Assumes conv_tick_i and meas_i come from logic on clk_i; the front
 * panel switch is asynchronous and is synchronised here.
 */
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tec_cfg.svh"

module tec_driver_output_control #(
   parameter int unsigned OV_CYCLES = `TEC_OV_TIME_MS * `TEC_CLK_KHZ,
   parameter int          CW        = 16
) (
   input  wire logic                  clk_i,
   input  wire logic                  srst_i,
   input  wire logic                  conv_tick_i,
   input  wire tec_pkg::meas_t        meas_i,
   input  wire logic signed [CW-1:0]  pid_value_i,
   input  wire logic                  front_panel_on_i,
   output logic signed      [CW-1:0]  tec_current_o,
   output tec_pkg::exc_t              excitation_sel_o,
   output logic                       hw_fault_o,
   output logic                       irq_o,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   localparam int              CNT_W  = 27;
   localparam logic [CNT_W-1:0] OV_LIM = CNT_W'(OV_CYCLES);

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction : merge

   // -------------------------------------------------------------------
   // Register and bus state
   // -------------------------------------------------------------------
   tec_pkg::ctrl_t   ctrl_q,    ctrl_d;
   logic [9:0]       slew_q,    slew_d;
   logic [15:0]      setp_q,    setp_d;
   logic [15:0]      vmax_q,    vmax_d;
   logic [15:0]      ivl_q,     ivl_d;
   logic [2:0]       ist_q,     ist_d;
   logic [2:0]       imask_q,   imask_d;
   logic [7:0]       awaddr_q,  awaddr_d;
   logic             aw_full_q, aw_full_d;
   logic [31:0]      wdata_q,   wdata_d;
   logic [3:0]       wstrb_q,   wstrb_d;
   logic             w_full_q,  w_full_d;
   logic             awrdy_q,   awrdy_d;
   logic             wrdy_q,    wrdy_d;
   logic             bvalid_q,  bvalid_d;
   logic [1:0]       bresp_q,   bresp_d;
   logic             arrdy_q,   arrdy_d;
   logic             rvalid_q,  rvalid_d;
   logic [31:0]      rdata_q,   rdata_d;
   logic [1:0]       rresp_q,   rresp_d;
   logic             irq_q,     irq_d;

   // -------------------------------------------------------------------
   // Control state
   // -------------------------------------------------------------------
   tec_pkg::exc_t         exc_q,     exc_d;
   logic signed [CW-1:0]  out_q,     out_d;
   logic [CNT_W-1:0]      ov_cnt_q,  ov_cnt_d;
   logic                  trip_q,    trip_d;
   logic                  seen_q,    seen_d;
   logic                  fp1_q,     fp2_q,  fp3_q;
   logic                  fp_q,      fp_d;
   logic                  enable;
   logic                  over;
   logic                  trip_ev;
   logic                  fault_ev;
   logic                  exc_ev;
   logic signed [CW-1:0]  target;
   logic signed [CW-1:0]  slew_next;
   logic [25:0]           step;
   logic [31:0]           wval;

   assign step = 26'(slew_q) * 26'(ivl_q); // A/s times ms gives mA

   tec_slew_step #(.W(CW), .SW(26)) u_step (
      .cur_i    (out_q),
      .target_i (target),
      .step_i   (step),
      .next_o   (slew_next)
   );

   // -------------------------------------------------------------------
   // Output control
   // -------------------------------------------------------------------
   always_comb begin
      // Second and third stage must agree before the switch moves
      fp_d   = (fp2_q == fp3_q) ? fp3_q : fp_q;
      enable = ctrl_q.sw_on & fp_q;
      target = ctrl_q.pid_sel ? pid_value_i : signed'(setp_q);
      over   = meas_i.vmon_mv > vmax_q;

      ov_cnt_d = ov_cnt_q;
      if (!over) begin
         ov_cnt_d = '0;
      end else if (ov_cnt_q != OV_LIM) begin
         ov_cnt_d = ov_cnt_q + CNT_W'(1);
      end
      // Counting to the limit plus one cycle makes it strictly longer
      trip_ev  = over && (ov_cnt_q == OV_LIM) && !trip_q;
      fault_ev = trip_ev && !seen_q;
      seen_d   = seen_q | trip_ev;

      trip_d = trip_q;
      if (trip_ev) begin
         trip_d = 1'b1;
      end else if (target == '0 || !enable) begin
         trip_d = 1'b0;
      end

      out_d = out_q;
      if (!enable || trip_q || trip_ev) begin
         out_d = '0;
      end else if (conv_tick_i) begin
         // Restarting from zero ramps back to the kept target
         out_d = slew_next;
      end

      // Only a magnitude is chosen; no direction control exists
      exc_d = exc_q;
      case (ctrl_q.mode)
         `TEC_MODE_1MA:   exc_d = tec_pkg::EXC_1MA;
         `TEC_MODE_100UA: exc_d = tec_pkg::EXC_100UA;
         `TEC_MODE_10UA:  exc_d = tec_pkg::EXC_10UA;
         default: begin
            if (!ctrl_q.resistive) begin
               exc_d = tec_pkg::EXC_1MA;
            end else if (conv_tick_i && meas_i.valid) begin
               // Moves only on reaching or passing the far edge of an overlap
               case (exc_q)
                  tec_pkg::EXC_1MA: begin
                     if (meas_i.res_ohm >= `TEC_R_LO_UP) begin
                        exc_d = tec_pkg::EXC_100UA;
                     end
                  end
                  tec_pkg::EXC_100UA: begin
                     if (meas_i.res_ohm < `TEC_R_LO_DOWN) begin
                        exc_d = tec_pkg::EXC_1MA;
                     end else if (meas_i.res_ohm > `TEC_R_HI_UP) begin
                        exc_d = tec_pkg::EXC_10UA;
                     end
                  end
                  default: begin
                     if (meas_i.res_ohm <= `TEC_R_HI_DOWN) begin
                        exc_d = tec_pkg::EXC_100UA;
                     end
                  end
               endcase
            end
         end
      endcase
      exc_ev = exc_d != exc_q;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         exc_q    <= tec_pkg::EXC_1MA;
         out_q    <= '0;
         ov_cnt_q <= '0;
         trip_q   <= 1'b0;
         seen_q   <= 1'b0;
         fp1_q    <= 1'b0;
         fp2_q    <= 1'b0;
         fp3_q    <= 1'b0;
         fp_q     <= 1'b0;
      end else begin
         exc_q    <= exc_d;
         out_q    <= out_d;
         ov_cnt_q <= ov_cnt_d;
         trip_q   <= trip_d;
         seen_q   <= seen_d;
         fp1_q    <= front_panel_on_i;
         fp2_q    <= fp1_q;
         fp3_q    <= fp2_q;
         fp_q     <= fp_d;
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite slave and registers
   // -------------------------------------------------------------------
   always_comb begin
      ctrl_d    = ctrl_q;
      slew_d    = slew_q;
      setp_d    = setp_q;
      vmax_d    = vmax_q;
      ivl_d     = ivl_q;
      imask_d   = imask_q;
      awaddr_d  = awaddr_q;
      aw_full_d = aw_full_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      w_full_d  = w_full_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      ist_d     = ist_q;
      wval      = '0;

      if (s_axi_awvalid && awrdy_q) begin
         awaddr_d  = s_axi_awaddr;
         aw_full_d = 1'b1;
      end
      if (s_axi_wvalid && wrdy_q) begin
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
         w_full_d = 1'b1;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end

      // Write once address and data are both held
      if (aw_full_q && w_full_q && !bvalid_q) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = `TEC_RESP_OKAY;
         case (awaddr_q)
            `TEC_OFF_CTRL: begin
               wval   = merge({27'h0, ctrl_q}, wdata_q, wstrb_q);
               ctrl_d = wval[4:0];
            end
            `TEC_OFF_SLEW: begin
               wval   = merge({22'h0, slew_q}, wdata_q, wstrb_q);
               // Out-of-range requests clamp to the top rate
               slew_d = (wval > 32'(`TEC_SLEW_MAX)) ? `TEC_SLEW_MAX : wval[9:0];
            end
            `TEC_OFF_SETP: begin
               wval   = merge({16'h0, setp_q}, wdata_q, wstrb_q);
               setp_d = wval[15:0];
            end
            `TEC_OFF_VMAX: begin
               wval   = merge({16'h0, vmax_q}, wdata_q, wstrb_q);
               vmax_d = wval[15:0];
            end
            `TEC_OFF_IVL: begin
               wval  = merge({16'h0, ivl_q}, wdata_q, wstrb_q);
               ivl_d = wval[15:0];
            end
            `TEC_OFF_IRQ_STAT: begin
               if (wstrb_q[0]) begin
                  ist_d = ist_q & ~wdata_q[2:0];
               end
            end
            `TEC_OFF_IRQ_MASK: begin
               wval    = merge({29'h0, imask_q}, wdata_q, wstrb_q);
               imask_d = wval[2:0];
            end
            `TEC_OFF_STATUS, `TEC_OFF_OUTPUT: begin
               bresp_d = `TEC_RESP_OKAY;
            end
            default: bresp_d = `TEC_RESP_SLVERR;
         endcase
      end

      // Hardware events win over a clear in the same cycle
      ist_d[`TEC_IRQ_TRIP]  = ist_d[`TEC_IRQ_TRIP]  | trip_ev;
      ist_d[`TEC_IRQ_FAULT] = ist_d[`TEC_IRQ_FAULT] | fault_ev;
      ist_d[`TEC_IRQ_EXC]   = ist_d[`TEC_IRQ_EXC]   | exc_ev;
      irq_d = |(ist_d & imask_d);

      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && arrdy_q) begin
         rvalid_d = 1'b1;
         rresp_d  = `TEC_RESP_OKAY;
         case (s_axi_araddr)
            `TEC_OFF_CTRL:     rdata_d = {27'h0, ctrl_q};
            `TEC_OFF_SLEW:     rdata_d = {22'h0, slew_q};
            `TEC_OFF_SETP:     rdata_d = {16'h0, setp_q};
            `TEC_OFF_VMAX:     rdata_d = {16'h0, vmax_q};
            `TEC_OFF_IVL:      rdata_d = {16'h0, ivl_q};
            `TEC_OFF_STATUS:   rdata_d = {26'h0, fp_q, enable, seen_q, trip_q, exc_q};
            `TEC_OFF_OUTPUT:   rdata_d = {{16{out_q[CW-1]}}, out_q};
            `TEC_OFF_IRQ_STAT: rdata_d = {29'h0, ist_q};
            `TEC_OFF_IRQ_MASK: rdata_d = {29'h0, imask_q};
            default: begin
               rdata_d = '0;
               rresp_d = `TEC_RESP_SLVERR;
            end
         endcase
      end

      awrdy_d = !aw_full_d && !bvalid_d;
      wrdy_d  = !w_full_d && !bvalid_d;
      arrdy_d = !rvalid_d;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_q    <= `TEC_CTRL_RST;
         slew_q    <= `TEC_SLEW_RST;
         setp_q    <= '0;
         vmax_q    <= `TEC_VMAX_RST;
         ivl_q     <= `TEC_IVL_RST;
         ist_q     <= '0;
         imask_q   <= '0;
         awaddr_q  <= '0;
         aw_full_q <= 1'b0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         w_full_q  <= 1'b0;
         awrdy_q   <= 1'b0;
         wrdy_q    <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= '0;
         arrdy_q   <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= '0;
         irq_q     <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         slew_q    <= slew_d;
         setp_q    <= setp_d;
         vmax_q    <= vmax_d;
         ivl_q     <= ivl_d;
         ist_q     <= ist_d;
         imask_q   <= imask_d;
         awaddr_q  <= awaddr_d;
         aw_full_q <= aw_full_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         w_full_q  <= w_full_d;
         awrdy_q   <= awrdy_d;
         wrdy_q    <= wrdy_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         arrdy_q   <= arrdy_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
         irq_q     <= irq_d;
      end
   end

   assign tec_current_o    = out_q;
   assign excitation_sel_o = exc_q;
   assign hw_fault_o       = seen_q;
   assign irq_o            = irq_q;
   assign s_axi_awready    = awrdy_q;
   assign s_axi_wready     = wrdy_q;
   assign s_axi_bvalid     = bvalid_q;
   assign s_axi_bresp      = bresp_q;
   assign s_axi_arready    = arrdy_q;
   assign s_axi_rvalid     = rvalid_q;
   assign s_axi_rdata      = rdata_q;
   assign s_axi_rresp      = rresp_q;

endmodule : tec_driver_output_control

// file: verilog/tec_pkg.sv
/*
 * Types shared by the TEC driver output control block.
 * Assumes the constants of tec_cfg.svh for encodings.
 */
package tec_pkg;

   // Excitation current selection driven to the sensor source
   typedef enum logic [1:0] {
      EXC_1MA,
      EXC_100UA,
      EXC_10UA
   } exc_t;

   // Control register layout
   typedef struct packed {
      logic       pid_sel;
      logic       sw_on;
      logic       resistive;
      logic [1:0] mode;
   } ctrl_t;

   // Measurements delivered with each conversion
   typedef struct packed {
      logic [15:0] vmon_mv;
      logic [31:0] res_ohm;
      logic        valid;
   } meas_t;

endpackage : tec_pkg

// file: verilog/tec_slew_step.sv
/*
 * One slew-limited step of the TEC current toward its target.
 * Assumes signed currents and an unsigned step size in the same unit.
 */
`timescale 1ns/1ps

module tec_slew_step #(
   parameter int W  = 16,
   parameter int SW = 26
) (
   input  wire logic signed [W-1:0]  cur_i,
   input  wire logic signed [W-1:0]  target_i,
   input  wire logic        [SW-1:0] step_i,
   output logic signed      [W-1:0]  next_o
);

   logic signed [W:0] diff;
   logic        [W:0] mag;

   always_comb begin
      diff = {target_i[W-1], target_i} - {cur_i[W-1], cur_i};
      mag  = diff[W] ? (W+1)'(-diff) : diff;
      // Landing exactly on the target within the step
      if (SW'(mag) <= step_i) begin
         next_o = target_i;
      end else if (diff[W]) begin
         next_o = cur_i - W'(step_i);
      end else begin
         next_o = cur_i + W'(step_i);
      end
   end

endmodule : tec_slew_step
